// File: acl_defs.svh
`ifndef ACL_DEFS_SVH
`define ACL_DEFS_SVH

// Register offsets
`define ACL_OFF_SIDE_SRC 8'h3c
`define ACL_OFF_DIV 8'h44
`define ACL_OFF_RATE 8'h46
`define ACL_OFF_INPUT 8'h48

// Side-tone source fields
`define ACL_LSRC_HI 13
`define ACL_LSRC_LO 12
`define ACL_RSRC_HI 11
`define ACL_RSRC_LO 10

// Divider register fields
`define ACL_LGAIN_HI 11
`define ACL_LGAIN_LO 8
`define ACL_RGAIN_HI 7
`define ACL_RGAIN_LO 4
`define ACL_POL_BIT 3
`define ACL_DSEL_HI 2
`define ACL_DSEL_LO 0

// Frame rate register fields
`define ACL_FEN_BIT 11
`define ACL_RATE_HI 10
`define ACL_RATE_LO 0
`define ACL_FSTAT_BIT 15

// Input routing fields
`define ACL_IN2R_BIT 10
`define ACL_IN1RN_BIT 9
`define ACL_IN1RP_BIT 8
`define ACL_IN2L_BIT 2
`define ACL_IN1LN_BIT 1
`define ACL_IN1LP_BIT 0

// Reset values
`define ACL_RST_GAIN 4'h0
`define ACL_RST_SRC 2'h0
`define ACL_RST_DSEL 3'h0
`define ACL_RST_RATE 11'h040
`define ACL_RST_IN2 1'h0
`define ACL_RST_IN1 1'h1

// Divider periods in system clocks
`define ACL_PER_1 3'h1
`define ACL_PER_2 3'h2
`define ACL_PER_3 3'h3
`define ACL_PER_4 3'h4
`define ACL_PER_5 3'h5
`define ACL_PER_6 3'h6

`endif

// File: acl_pkg.sv
package acl_pkg;

  typedef enum logic [2:0] {
    ACL_DIV_1   = 3'h0,
    ACL_DIV_1P5 = 3'h1,
    ACL_DIV_2   = 3'h2,
    ACL_DIV_3   = 3'h3,
    ACL_DIV_4   = 3'h4,
    ACL_DIV_5P5 = 3'h5,
    ACL_DIV_6   = 3'h6,
    ACL_DIV_RSV = 3'h7
  } acl_div_sel_t;

  typedef enum logic [1:0] {
    ACL_SRC_NONE  = 2'h0,
    ACL_SRC_LEFT  = 2'h1,
    ACL_SRC_RIGHT = 2'h2,
    ACL_SRC_UNUSED = 2'h3
  } acl_src_t;

  typedef enum logic {
    ACL_PH_LEFT  = 1'b0,
    ACL_PH_RIGHT = 1'b1
  } acl_phase_t;

endpackage

// File: acl_conv_div.sv
`timescale 1ns/1ns
`include "acl_defs.svh"

module acl_conv_div (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Control
  input wire logic [2:0] divSel,
  // Output
  output logic tick
);

  logic [2:0] cnt_r, cnt_nxt;
  logic alt_r, alt_nxt;
  logic tick_r, tick_nxt;
  logic [2:0] period;
  logic frac;
  logic run;

  ////////////////////////////////////////////////////////////////////////////
  // Period select
  always_comb begin
    frac = 1'b0;
    run = 1'b1;
    case (acl_pkg::acl_div_sel_t'(divSel))
      acl_pkg::ACL_DIV_1: period = `ACL_PER_1;
      acl_pkg::ACL_DIV_1P5: begin
        period = `ACL_PER_1; // RQ13
        frac = 1'b1;
      end
      acl_pkg::ACL_DIV_2: period = `ACL_PER_2;
      acl_pkg::ACL_DIV_3: period = `ACL_PER_3;
      acl_pkg::ACL_DIV_4: period = `ACL_PER_4;
      acl_pkg::ACL_DIV_5P5: begin
        period = `ACL_PER_5; // RQ13
        frac = 1'b1;
      end
      acl_pkg::ACL_DIV_6: period = `ACL_PER_6;
      default: begin
        period = `ACL_PER_1;
        run = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, alternating long and short periods for fractional ratios
  always_comb begin
    cnt_nxt = cnt_r;
    alt_nxt = alt_r;
    tick_nxt = 1'b0;
    if (!run) begin
      cnt_nxt = 3'h0;
      alt_nxt = 1'b0;
    end else if (cnt_r >= period - 3'h1 + {2'h0, frac & alt_r}) begin // RQ3
      cnt_nxt = 3'h0;
      tick_nxt = 1'b1;
      alt_nxt = frac ? ~alt_r : 1'b0; // RQ13
    end else begin
      cnt_nxt = cnt_r + 3'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt_r <= 3'h0;
      alt_r <= 1'b0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      alt_r <= alt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule // acl_conv_div

// File: acl_record_clk.sv
`timescale 1ns/1ns
`include "acl_defs.svh"

// Overview of operation
// RQ1: Left side-tone gain, four bits, 3 dB steps, -36 to 0 dB, resets zero.
// RQ2: Right side-tone gain, four bits, same steps and range, resets zero.
// RQ3: Divider select divides system clock by 1,1.5,2,3,4,5.5,6; 111 reserved.
// RQ4: One enable bit starts frame clock generation; reset value off.
// RQ5: Eleven-bit field gives bit clocks per frame phase; resets to 64.
// RQ6: Software programs phase length only 8 to 2047 while enabled.
// RQ7: Bit attaches second right input pin to right amplifier; resets detached.
// RQ8: Bit connects right negative input to amplifier negative; resets connected.
// RQ9: Bit connects right positive input to amplifier positive; resets connected.
// RQ10: Bit attaches second left input pin to left amplifier; resets detached.
// RQ11: Side-tone gain applies only with source selected; code 11 unused.
// RQ12: Frame clock toggles every phase length when enabled, else held static.
// RQ13: Fractional ratios alternate integer periods to match average rate.

module acl_record_clk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  output logic [15:0] regRdData,
  output logic regRdValid,
  // Bit clock from the audio interface
  input wire logic bitClkTick,
  // Converter clock
  output logic convTick,
  output logic convClk,
  // Frame clock
  output logic frameClk,
  output logic frameEdge,
  // Side-tone
  output logic [3:0] leftSidetoneGain,
  output logic [3:0] rightSidetoneGain,
  output logic [1:0] leftSidetoneSource,
  output logic [1:0] rightSidetoneSource,
  output logic leftSidetoneMixEn,
  output logic rightSidetoneMixEn,
  // Input pin routing
  output logic rightAuxInConnect,
  output logic rightNegInConnect,
  output logic rightPosInConnect,
  output logic leftAuxInConnect,
  output logic leftNegInConnect,
  output logic leftPosInConnect
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [3:0] lGain_r, lGain_nxt;
  logic [3:0] rGain_r, rGain_nxt;
  logic [1:0] lSrc_r, lSrc_nxt;
  logic [1:0] rSrc_r, rSrc_nxt;
  logic pol_r, pol_nxt;
  logic [2:0] dSel_r, dSel_nxt;
  logic fEn_r, fEn_nxt;
  logic [10:0] rate_r, rate_nxt;
  logic [5:0] route_r, route_nxt;
  logic [15:0] rdData_r, rdData_nxt;
  logic rdValid_r, rdValid_nxt;
  logic lMix_r, lMix_nxt;
  logic rMix_r, rMix_nxt;

  logic wrSrc, wrDiv, wrRate, wrIn;

  assign wrSrc = regWrEn && (regAddr == `ACL_OFF_SIDE_SRC);
  assign wrDiv = regWrEn && (regAddr == `ACL_OFF_DIV);
  assign wrRate = regWrEn && (regAddr == `ACL_OFF_RATE);
  assign wrIn = regWrEn && (regAddr == `ACL_OFF_INPUT);

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_comb begin
    lGain_nxt = lGain_r;
    rGain_nxt = rGain_r;
    lSrc_nxt = lSrc_r;
    rSrc_nxt = rSrc_r;
    pol_nxt = pol_r;
    dSel_nxt = dSel_r;
    fEn_nxt = fEn_r;
    rate_nxt = rate_r;
    route_nxt = route_r;
    if (wrSrc) begin
      lSrc_nxt = regWrData[`ACL_LSRC_HI:`ACL_LSRC_LO]; // RQ11
      rSrc_nxt = regWrData[`ACL_RSRC_HI:`ACL_RSRC_LO]; // RQ11
    end
    if (wrDiv) begin
      lGain_nxt = regWrData[`ACL_LGAIN_HI:`ACL_LGAIN_LO]; // RQ1
      rGain_nxt = regWrData[`ACL_RGAIN_HI:`ACL_RGAIN_LO]; // RQ2
      pol_nxt = regWrData[`ACL_POL_BIT];
      dSel_nxt = regWrData[`ACL_DSEL_HI:`ACL_DSEL_LO]; // RQ3
    end
    if (wrRate) begin
      fEn_nxt = regWrData[`ACL_FEN_BIT]; // RQ4
      rate_nxt = regWrData[`ACL_RATE_HI:`ACL_RATE_LO]; // RQ5
    end
    if (wrIn) begin
      route_nxt[5] = regWrData[`ACL_IN2R_BIT]; // RQ7
      route_nxt[4] = regWrData[`ACL_IN1RN_BIT]; // RQ8
      route_nxt[3] = regWrData[`ACL_IN1RP_BIT]; // RQ9
      route_nxt[2] = regWrData[`ACL_IN2L_BIT]; // RQ10
      route_nxt[1] = regWrData[`ACL_IN1LN_BIT];
      route_nxt[0] = regWrData[`ACL_IN1LP_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Side-tone mix enables, code 11 treated as no mix
  always_comb begin
    lMix_nxt = (acl_pkg::acl_src_t'(lSrc_nxt) == acl_pkg::ACL_SRC_LEFT) ||
               (acl_pkg::acl_src_t'(lSrc_nxt) == acl_pkg::ACL_SRC_RIGHT); // RQ11
    rMix_nxt = (acl_pkg::acl_src_t'(rSrc_nxt) == acl_pkg::ACL_SRC_LEFT) ||
               (acl_pkg::acl_src_t'(rSrc_nxt) == acl_pkg::ACL_SRC_RIGHT); // RQ11
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lMix_r <= 1'b0;
      rMix_r <= 1'b0;
    end else begin
      lMix_r <= lMix_nxt;
      rMix_r <= rMix_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame clock generation
  logic [10:0] bitCnt_r, bitCnt_nxt;
  acl_pkg::acl_phase_t phase_r, phase_nxt;
  logic frameEdge_r, frameEdge_nxt;
  logic [10:0] lastCnt;

  // Rate 0 wraps to a full 2048-count phase
  assign lastCnt = rate_r - 11'h001;

  always_comb begin
    bitCnt_nxt = bitCnt_r;
    phase_nxt = phase_r;
    frameEdge_nxt = 1'b0;
    if (!fEn_r) begin
      bitCnt_nxt = 11'h000; // RQ4
      phase_nxt = acl_pkg::ACL_PH_LEFT; // RQ12
    end else if (bitClkTick) begin
      if (bitCnt_r >= lastCnt) begin // RQ6
        bitCnt_nxt = 11'h000;
        frameEdge_nxt = 1'b1;
        case (phase_r)
          acl_pkg::ACL_PH_LEFT: phase_nxt = acl_pkg::ACL_PH_RIGHT; // RQ12
          acl_pkg::ACL_PH_RIGHT: phase_nxt = acl_pkg::ACL_PH_LEFT; // RQ12
          default: phase_nxt = acl_pkg::ACL_PH_LEFT;
        endcase
      end else begin
        bitCnt_nxt = bitCnt_r + 11'h001; // RQ5
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bitCnt_r <= 11'h000;
      phase_r <= acl_pkg::ACL_PH_LEFT;
      frameEdge_r <= 1'b0;
    end else begin
      bitCnt_r <= bitCnt_nxt;
      phase_r <= phase_nxt;
      frameEdge_r <= frameEdge_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock
  logic divTick;
  logic convPh_r, convPh_nxt;
  logic convClk_r, convClk_nxt;
  logic convTick_r, convTick_nxt;

  acl_conv_div uDiv (
    .ref_clk(ref_clk),
    .rst(rst),
    .divSel(dSel_r),
    .tick(divTick)
  );

  // Polarity takes effect one cycle after its write
  always_comb begin
    convTick_nxt = divTick; // RQ3
    convPh_nxt = divTick ? ~convPh_r : convPh_r;
    convClk_nxt = convPh_nxt ^ pol_r;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      convPh_r <= 1'b0;
      convClk_r <= 1'b0;
      convTick_r <= 1'b0;
    end else begin
      convPh_r <= convPh_nxt;
      convClk_r <= convClk_nxt;
      convTick_r <= convTick_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read back
  always_comb begin
    rdData_nxt = 16'h0000;
    rdValid_nxt = regRdEn;
    if (regRdEn) begin
      case (regAddr)
        `ACL_OFF_SIDE_SRC: begin
          rdData_nxt[`ACL_LSRC_HI:`ACL_LSRC_LO] = lSrc_r;
          rdData_nxt[`ACL_RSRC_HI:`ACL_RSRC_LO] = rSrc_r;
        end
        `ACL_OFF_DIV: begin
          rdData_nxt[`ACL_LGAIN_HI:`ACL_LGAIN_LO] = lGain_r;
          rdData_nxt[`ACL_RGAIN_HI:`ACL_RGAIN_LO] = rGain_r;
          rdData_nxt[`ACL_POL_BIT] = pol_r;
          rdData_nxt[`ACL_DSEL_HI:`ACL_DSEL_LO] = dSel_r;
        end
        `ACL_OFF_RATE: begin
          rdData_nxt[`ACL_FSTAT_BIT] = phase_r;
          rdData_nxt[`ACL_FEN_BIT] = fEn_r;
          rdData_nxt[`ACL_RATE_HI:`ACL_RATE_LO] = rate_r;
        end
        `ACL_OFF_INPUT: begin
          rdData_nxt[`ACL_IN2R_BIT] = route_r[5];
          rdData_nxt[`ACL_IN1RN_BIT] = route_r[4];
          rdData_nxt[`ACL_IN1RP_BIT] = route_r[3];
          rdData_nxt[`ACL_IN2L_BIT] = route_r[2];
          rdData_nxt[`ACL_IN1LN_BIT] = route_r[1];
          rdData_nxt[`ACL_IN1LP_BIT] = route_r[0];
        end
        default: rdData_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdData_r <= 16'h0000;
      rdValid_r <= 1'b0;
    end else begin
      rdData_r <= rdData_nxt;
      rdValid_r <= rdValid_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lGain_r <= `ACL_RST_GAIN; // RQ1
      rGain_r <= `ACL_RST_GAIN; // RQ2
      lSrc_r <= `ACL_RST_SRC;
      rSrc_r <= `ACL_RST_SRC;
      pol_r <= 1'b0;
      dSel_r <= `ACL_RST_DSEL;
      fEn_r <= 1'b0; // RQ4
      rate_r <= `ACL_RST_RATE; // RQ5
      route_r <= {`ACL_RST_IN2, `ACL_RST_IN1, `ACL_RST_IN1,
                  `ACL_RST_IN2, `ACL_RST_IN1, `ACL_RST_IN1}; // RQ7
    end else begin
      lGain_r <= lGain_nxt;
      rGain_r <= rGain_nxt;
      lSrc_r <= lSrc_nxt;
      rSrc_r <= rSrc_nxt;
      pol_r <= pol_nxt;
      dSel_r <= dSel_nxt;
      fEn_r <= fEn_nxt;
      rate_r <= rate_nxt;
      route_r <= route_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign regRdData = rdData_r;
  assign regRdValid = rdValid_r;
  assign convTick = convTick_r;
  assign convClk = convClk_r;
  assign frameClk = phase_r; // RQ12
  assign frameEdge = frameEdge_r;
  assign leftSidetoneGain = lGain_r; // RQ1
  assign rightSidetoneGain = rGain_r; // RQ2
  assign leftSidetoneSource = lSrc_r;
  assign rightSidetoneSource = rSrc_r;
  assign leftSidetoneMixEn = lMix_r; // RQ11
  assign rightSidetoneMixEn = rMix_r; // RQ11
  assign rightAuxInConnect = route_r[5]; // RQ7
  assign rightNegInConnect = route_r[4]; // RQ8
  assign rightPosInConnect = route_r[3]; // RQ9
  assign leftAuxInConnect = route_r[2]; // RQ10
  assign leftNegInConnect = route_r[1];
  assign leftPosInConnect = route_r[0];

endmodule // acl_record_clk

// File: acl_record_clk_assertions.sv
`timescale 1ns/1ns
module acl_rc_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [15:0] regWrData,
  input wire logic regRdValid,
  // Watched outputs
  input wire logic convTick,
  input wire logic frameClk,
  input wire logic frameEdge,
  input wire logic [3:0] leftSidetoneGain,
  input wire logic [3:0] rightSidetoneGain,
  input wire logic [1:0] leftSidetoneSource,
  input wire logic leftSidetoneMixEn,
  input wire logic rightAuxInConnect
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [2:0] divSel_r;
  logic frameEn_r;
  ////////////////////////////////////////////////////////////////////////////
  // Shadow of divider select and frame enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      divSel_r <= 3'h0;
      frameEn_r <= 1'b0;
    end else if (regWrEn && regAddr == 8'h44) begin
      divSel_r <= regWrData[2:0];
    end else if (regWrEn && regAddr == 8'h46) begin
      frameEn_r <= regWrData[11];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_lgain_write: assert property (
    regWrEn && regAddr == 8'h44 |=>
    leftSidetoneGain == $past(regWrData[11:8]))
    else $error("left gain not taken from write");
  a_rgain_write: assert property (
    regWrEn && regAddr == 8'h44 |=>
    rightSidetoneGain == $past(regWrData[7:4]))
    else $error("right gain not taken from write");
  a_conv_stop: assert property (
    divSel_r == 3'h7 [*3] |-> !convTick)
    else $error("converter tick with reserved select");
  a_frame_off: assert property (
    !frameEn_r [*2] |-> !frameClk && !frameEdge)
    else $error("frame clock active while disabled");
  a_read_valid: assert property (
    regRdEn |=> regRdValid)
    else $error("read not answered next cycle");
  a_aux_write: assert property (
    regWrEn && regAddr == 8'h48 |=>
    rightAuxInConnect == $past(regWrData[10]))
    else $error("right aux switch not taken from write");
  a_mix_match: assert property (
    leftSidetoneMixEn == (leftSidetoneSource inside {2'h1, 2'h2}))
    else $error("left mix enable does not follow source");
  a_edge_rise: assert property (
    $rose(frameClk) |-> frameEdge)
    else $error("frame clock rose without edge pulse");
  a_edge_cause: assert property (
    frameEdge |-> $changed(frameClk))
    else $error("edge pulse without frame clock change");
endmodule // acl_rc_chk

// File: acl_host_bclk.sv
`timescale 1ns/1ns
module acl_host_bclk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Pacing
  input wire logic run,
  input wire logic [3:0] gap,
  // Bit clock enable
  output logic bitClkTick
);
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  ////////////////////////////////////////////////////////////////////////////
  // One tick every gap+1 cycles; still when not running
  always_comb begin
    cnt_nxt = (cnt_r >= gap) ? 4'h0 : cnt_r + 4'h1;
    if (!run) cnt_nxt = 4'h0;
  end
  always_ff @(posedge ref_clk) begin
    if (rst) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  end
  assign bitClkTick = run && (cnt_r == gap);
endmodule // acl_host_bclk

// File: acl_record_clk_tb.sv
`timescale 1ns/1ns
module acl_record_clk_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic run = 1'b0;
  logic [3:0] gap = 4'h0;
  logic [15:0] regRdData;
  logic regRdValid, bitClkTick, convTick, convClk, frameClk, frameEdge;
  logic [3:0] leftSidetoneGain, rightSidetoneGain;
  logic [1:0] leftSidetoneSource, rightSidetoneSource;
  logic leftSidetoneMixEn, rightSidetoneMixEn, c0;
  logic rightAuxInConnect, rightNegInConnect, rightPosInConnect;
  logic leftAuxInConnect, leftNegInConnect, leftPosInConnect;
  int err_count = 0;
  int n_checks = 0;
  int n, d;
  logic [15:0] divExp [8] = '{16'h84, 16'h58, 16'h42, 16'h2c,
                              16'h21, 16'h18, 16'h16, 16'h00};
  logic [10:0] rates [3] = '{11'h008, 11'h008, 11'h7ff};
  logic [3:0] gaps [3] = '{4'h0, 4'h2, 4'h0};
  ////////////////////////////////////////////////////////////////////////////
  always #10 ref_clk = ~ref_clk;
  acl_host_bclk u_host (.ref_clk, .rst, .run, .gap, .bitClkTick);
  acl_record_clk DUT (.ref_clk, .rst, .regWrEn, .regRdEn, .regAddr,
    .regWrData, .regRdData, .regRdValid, .bitClkTick, .convTick, .convClk,
    .frameClk, .frameEdge, .leftSidetoneGain, .rightSidetoneGain,
    .leftSidetoneSource, .rightSidetoneSource, .leftSidetoneMixEn,
    .rightSidetoneMixEn, .rightAuxInConnect, .rightNegInConnect,
    .rightPosInConnect, .leftAuxInConnect, .leftNegInConnect,
    .leftPosInConnect);
  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(negedge ref_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = v;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    chk({15'h0, regRdValid}, 16'h0001);
    chk(regRdData, e);
  endtask
  task automatic nextEdge(output int k);
    k = 0;
    do begin
      @(negedge ref_clk);
      k++;
    end while (frameEdge !== 1'b1 && k < 5000);
    if (k >= 5000) begin
      err_count++;
      report_and_stop();
    end
  endtask
  function automatic logic [15:0] pins();
    return {10'h0, rightAuxInConnect, rightNegInConnect,
            rightPosInConnect, leftAuxInConnect, leftNegInConnect,
            leftPosInConnect};
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rd(8'h44, 16'h0000);
    rd(8'h46, 16'h0040);
    rd(8'h48, 16'h0303);
    rd(8'h50, 16'h0000);
    rd(8'h3c, 16'h0000);
    chk(pins(), 16'h001b);
    wr(8'h48, 16'hffff);
    chk(pins(), 16'h003f);
    rd(8'h48, 16'h0707);
    wr(8'h48, 16'h0000);
    chk(pins(), 16'h0000);
    wr(8'h44, 16'h0ca7);
    chk({8'h0, leftSidetoneGain, rightSidetoneGain}, 16'h00ca);
    rd(8'h44, 16'h0ca7);
    repeat (8) @(negedge ref_clk);
    c0 = convClk;
    wr(8'h44, 16'h0caf);
    @(negedge ref_clk);
    chk({15'h0, convClk}, {15'h0, ~c0});
    for (int c = 0; c < 4; c++) begin
      wr(8'h3c, 16'(c << 12 | c << 10));
      chk({14'h0, leftSidetoneMixEn, rightSidetoneMixEn},
          (c == 1 || c == 2) ? 16'h0003 : 16'h0000);
      chk({12'h0, leftSidetoneSource, rightSidetoneSource},
          16'(c << 2 | c));
      rd(8'h3c, 16'(c << 12 | c << 10));
    end
    for (int s = 0; s < 8; s++) begin
      wr(8'h44, 16'(s));
      repeat (12) @(negedge ref_clk);
      n = 0;
      repeat (132) begin
        @(negedge ref_clk);
        n += int'(convTick);
      end
      d = n - int'(divExp[s]);
      chk(16'(d >= -1 && d <= 1), 16'h0001);
    end
    for (int k = 0; k < 3; k++) begin
      gap = gaps[k];
      run = 1'b1;
      wr(8'h46, {5'h01, rates[k]});
      nextEdge(n);
      nextEdge(n);
      chk(16'(n), 16'(int'(rates[k]) * (int'(gaps[k]) + 1)));
    end
    wr(8'h46, 16'h0008);
    repeat (2) @(negedge ref_clk);
    n = 0;
    repeat (40) begin
      @(negedge ref_clk);
      n += int'(frameEdge | frameClk);
    end
    chk(16'(n), 16'h0000);
    run = 1'b0;
    report_and_stop();
  end
endmodule // acl_record_clk_tb

bind acl_record_clk acl_rc_chk u_chk (.ref_clk, .rst, .regWrEn, .regRdEn,
  .regAddr, .regWrData, .regRdValid, .convTick, .frameClk, .frameEdge,
  .leftSidetoneGain, .rightSidetoneGain, .leftSidetoneSource,
  .leftSidetoneMixEn, .rightAuxInConnect);
